/* File: ic4_core_model.sv */
// Purpose: Core-side model that marks instruction ends and returns from service.
// Assumes: Instruction length of 1 to 3 cycles; a length of 0 stalls the core.
// Notes: A requested return waits for the final cycle of an instruction.
`timescale 1ns/1ns
`default_nettype none
module ic4_core_model (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [1:0] LEN_I,
    input wire logic RETURN_FROM_INTERRUPT_REQ_I,
    output logic INSTR_END_O,
    output logic RETURN_FROM_INTERRUPT_O
);
    logic [1:0] cnt_q;
    logic ret_q;

    // Final cycle of each instruction, and a return only in that cycle.
    assign INSTR_END_O = (LEN_I != 2'h0) && (cnt_q == LEN_I - 2'h1);
    assign RETURN_FROM_INTERRUPT_O = ret_q && INSTR_END_O;

    // Cycle count within an instruction; a held return is kept until the end.
    // This keeps the controller from ever seeing a return in mid-instruction.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cnt_q <= 2'h0;
            ret_q <= 1'b0;
        end else begin
            cnt_q <= INSTR_END_O ? 2'h0 : cnt_q + 2'h1;
            ret_q <= RETURN_FROM_INTERRUPT_REQ_I || (ret_q && !INSTR_END_O);
        end
    end
endmodule // ic4_core_model
`default_nettype wire

/* File: ic4_ctrl.sv */
// Purpose: Fourteen-source, four-level interrupt controller for an 8-bit core.
// Assumes: All inputs synchronous to CLK_I; core marks instruction ends and returns.
// Notes: Peripheral flags other than timer 0/1 and the external pins live outside.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ic4_params.svh"

// Behaviour
// RULE1 - Fourteen sources, four priority levels.
// RULE2 - Request needs own enable and global gate.
// RULE3 - Software can set or clear flags; level-mode pin flags follow the pin instead.
// RULE4 - Global gate zero blocks every source.
// RULE5 - Level from high and low priority bits.
// RULE6 - Same level: fixed polling order wins.
// RULE7 - Vector is 0003H plus eight per source.
// RULE8 - Primary enable bit layout.
// RULE9 - Extra enable bit layout.
// RULE10 - Primary priority low/high bit layout.
// RULE11 - Extra priority low/high bit layout.
// RULE12 - Pins 2/3 control register layout.
// RULE13 - Pins 2/3 type: one edge, zero level.
// RULE14 - Pins 0/1 type: falling edge or low.
// RULE15 - Hardware sets flags; clears edge ones on vector.
// RULE16 - Bit pair encodes level 0 to 3.
// RULE17 - Preempt only strictly higher levels.
// RULE18 - One instruction after return or write.
// RULE19 - Keep stack of levels in service.
// RULE20 - Enables, priorities, types reset to zero.
// RULE21 - Core marks instruction ends and returns.
module ic4_ctrl (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire ic4_pkg::ic4_req_s REG_REQ_I,
    output logic [7:0] RDATA_O,
    input wire logic [3:0] EXT_N_I,
    input wire logic T0_OVF_I,
    input wire logic T1_OVF_I,
    input wire logic [7:0] PERI_REQ_I,
    input wire logic INSTR_END_I,
    input wire logic RETURN_FROM_INTERRUPT_I,
    output logic VEC_VALID_O,
    output logic [3:0] VEC_SRC_O,
    output logic [15:0] VEC_ADDR_O
);
    import ic4_pkg::*;

    ic4_state_s s_q;
    ic4_state_s s_d;
    logic [13:0] src_flag;
    logic [13:0] src_en;
    logic [13:0] src_lo;
    logic [13:0] src_hi;
    ic4_lvl_t src_lvl [0:13];
    logic [3:0] fall;
    logic reg_hit;
    logic [3:0] win_src;
    ic4_lvl_t win_lvl;
    logic win_found;
    ic4_lvl_t cur_lvl;
    logic cur_any;
    logic take;

    // Per-source views of flags, enables and priority bits, index 0 is the
    // highest polling priority and index 13 the lowest.
    assign src_flag = {PERI_REQ_I[7:2], s_q.ext23_ctl[`IC4_XC_EXT3_REQ],
                       s_q.ext23_ctl[`IC4_XC_EXT2_REQ], PERI_REQ_I[1:0],
                       s_q.tmr_ext_ctl[`IC4_TC_T1_OVF], s_q.tmr_ext_ctl[`IC4_TC_EXT1_REQ],
                       s_q.tmr_ext_ctl[`IC4_TC_T0_OVF],
                       s_q.tmr_ext_ctl[`IC4_TC_EXT0_REQ]}; // RULE1
    assign src_en = {s_q.xtr_en[`IC4_SRC_FIELD], s_q.ext23_ctl[`IC4_XC_EXT3_EN],
                     s_q.ext23_ctl[`IC4_XC_EXT2_EN], s_q.pri_en[`IC4_SRC_FIELD]}; // RULE8
    assign src_lo = {s_q.xtr_lo[`IC4_SRC_FIELD], s_q.ext23_ctl[`IC4_XC_EXT3_LO],
                     s_q.ext23_ctl[`IC4_XC_EXT2_LO], s_q.pri_lo[`IC4_SRC_FIELD]}; // RULE10
    assign src_hi = {s_q.xtr_hi[`IC4_SRC_FIELD], s_q.pri_hi}; // RULE11

    // Level per source: high bit over low bit gives levels 0 to 3.
    always_comb begin
        for (int i = 0; i < `IC4_NUM_SRC; i++) begin
            src_lvl[i] = {src_hi[i], src_lo[i]}; // RULE5 RULE16
        end
    end

    // Falling edges seen against the previous pin sample.
    assign fall = s_q.pin & ~EXT_N_I;

    // Any write to a register of this block holds off vectoring.
    always_comb begin
        reg_hit = 1'b0;
        if (REG_REQ_I.addr == `IC4_ADR_TIMER_EXT_CTRL) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_EN) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_EN) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_LO) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_HI) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_HI) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_LO) begin
            reg_hit = REG_REQ_I.wr;
        end else if (REG_REQ_I.addr == `IC4_ADR_EXT23_CTRL) begin
            reg_hit = REG_REQ_I.wr;
        end
    end

    // Poll the sampled requests: the highest level wins, and within a level
    // the lowest source number, because the later match overwrites.
    always_comb begin
        win_src = 4'h0;
        win_lvl = 2'h0;
        win_found = 1'b0;
        for (int lv = 0; lv < `IC4_NUM_LVL; lv++) begin
            for (int i = `IC4_NUM_SRC - 1; i >= 0; i--) begin
                if (s_q.pend[i] && (src_lvl[i] == ic4_lvl_t'(lv))) begin
                    win_src = 4'(i); // RULE6
                    win_lvl = ic4_lvl_t'(lv); // RULE17
                    win_found = 1'b1;
                end
            end
        end
    end

    // Highest level now in service.
    always_comb begin
        cur_lvl = 2'h0;
        cur_any = |s_q.act;
        for (int lv = 0; lv < `IC4_NUM_LVL; lv++) begin
            if (s_q.act[lv]) begin
                cur_lvl = ic4_lvl_t'(lv); // RULE19
            end
        end
    end

    // Vector only at an instruction end, never right after a blocker, and
    // only over a strictly lower level in service.
    assign take = INSTR_END_I && win_found && !s_q.blk && !reg_hit && !RETURN_FROM_INTERRUPT_I
                  && (!cur_any || (win_lvl > cur_lvl)); // RULE17 RULE18 RULE21

    // Next-state logic. Order inside: hardware clear on vector, then the
    // software write, then hardware sets, so a set in the clearing cycle wins.
    always_comb begin
        s_d = s_q;
        s_d.pin = EXT_N_I;
        s_d.rdata = 8'h00;
        s_d.vec.valid = take;

        // Marks the instruction in progress as a blocker until it ends.
        if (INSTR_END_I) begin
            s_d.blk = 1'b0; // RULE18
        end else if (reg_hit || RETURN_FROM_INTERRUPT_I) begin
            s_d.blk = 1'b1; // RULE18
        end

        // Return pops the top level; vectoring pushes the winner's level.
        if (RETURN_FROM_INTERRUPT_I) begin
            for (int lv = 0; lv < `IC4_NUM_LVL; lv++) begin
                if (s_q.act[lv] && ((s_q.act >> (lv + 1)) == 4'h0)) begin
                    s_d.act[lv] = 1'b0; // RULE19
                end
            end
        end
        if (take) begin
            s_d.act[win_lvl] = 1'b1; // RULE19
            s_d.vec.src = win_src;
            s_d.vec.lvl = win_lvl;
            s_d.vec.addr = `IC4_VEC_BASE + (16'(win_src) << `IC4_VEC_SHIFT); // RULE7
        end

        // Hardware clear on vectoring: timer flags always, pins only if edge.
        if (take) begin
            if (win_src == `IC4_SRC_T0) begin
                s_d.tmr_ext_ctl[`IC4_TC_T0_OVF] = 1'b0;
            end
            if (win_src == `IC4_SRC_T1) begin
                s_d.tmr_ext_ctl[`IC4_TC_T1_OVF] = 1'b0;
            end
            if ((win_src == `IC4_SRC_EXT0) && s_q.tmr_ext_ctl[`IC4_TC_EXT0_TYPE]) begin
                s_d.tmr_ext_ctl[`IC4_TC_EXT0_REQ] = 1'b0; // RULE15
            end
            if ((win_src == `IC4_SRC_EXT1) && s_q.tmr_ext_ctl[`IC4_TC_EXT1_TYPE]) begin
                s_d.tmr_ext_ctl[`IC4_TC_EXT1_REQ] = 1'b0; // RULE15
            end
            if ((win_src == `IC4_SRC_EXT2) && s_q.ext23_ctl[`IC4_XC_EXT2_TYPE]) begin
                s_d.ext23_ctl[`IC4_XC_EXT2_REQ] = 1'b0; // RULE15
            end
            if ((win_src == `IC4_SRC_EXT3) && s_q.ext23_ctl[`IC4_XC_EXT3_TYPE]) begin
                s_d.ext23_ctl[`IC4_XC_EXT3_REQ] = 1'b0; // RULE15
            end
        end

        // Software writes; unused bits stay zero.
        if (REG_REQ_I.wr) begin
            if (REG_REQ_I.addr == `IC4_ADR_TIMER_EXT_CTRL) begin
                s_d.tmr_ext_ctl = REG_REQ_I.wdata & `IC4_MASK_TIMER_EXT; // RULE3
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_EN) begin
                s_d.pri_en = REG_REQ_I.wdata & `IC4_MASK_PRIMARY_EN; // RULE8
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_EN) begin
                s_d.xtr_en = REG_REQ_I.wdata & `IC4_MASK_EXTRA; // RULE9
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_LO) begin
                s_d.xtr_lo = REG_REQ_I.wdata & `IC4_MASK_EXTRA; // RULE11
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_HI) begin
                s_d.xtr_hi = REG_REQ_I.wdata & `IC4_MASK_EXTRA; // RULE11
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_HI) begin
                s_d.pri_hi = REG_REQ_I.wdata; // RULE10
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_LO) begin
                s_d.pri_lo = REG_REQ_I.wdata & `IC4_MASK_PRIMARY_LO; // RULE10
            end else if (REG_REQ_I.addr == `IC4_ADR_EXT23_CTRL) begin
                s_d.ext23_ctl = REG_REQ_I.wdata; // RULE12 RULE3
            end
        end

        // Hardware sets: timer overflow pulses and falling edges.
        if (T0_OVF_I) begin
            s_d.tmr_ext_ctl[`IC4_TC_T0_OVF] = 1'b1;
        end
        if (T1_OVF_I) begin
            s_d.tmr_ext_ctl[`IC4_TC_T1_OVF] = 1'b1;
        end
        if (s_q.tmr_ext_ctl[`IC4_TC_EXT0_TYPE] && fall[0]) begin
            s_d.tmr_ext_ctl[`IC4_TC_EXT0_REQ] = 1'b1; // RULE14 RULE15
        end
        if (s_q.tmr_ext_ctl[`IC4_TC_EXT1_TYPE] && fall[1]) begin
            s_d.tmr_ext_ctl[`IC4_TC_EXT1_REQ] = 1'b1; // RULE14 RULE15
        end
        if (s_q.ext23_ctl[`IC4_XC_EXT2_TYPE] && fall[2]) begin
            s_d.ext23_ctl[`IC4_XC_EXT2_REQ] = 1'b1; // RULE13
        end
        if (s_q.ext23_ctl[`IC4_XC_EXT3_TYPE] && fall[3]) begin
            s_d.ext23_ctl[`IC4_XC_EXT3_REQ] = 1'b1; // RULE13
        end

        // Level mode: the pin owns the flag, so a software write to it is
        // overridden in the same cycle. A missed level request is not kept.
        if (!s_q.tmr_ext_ctl[`IC4_TC_EXT0_TYPE]) begin
            s_d.tmr_ext_ctl[`IC4_TC_EXT0_REQ] = ~EXT_N_I[0]; // RULE14
        end
        if (!s_q.tmr_ext_ctl[`IC4_TC_EXT1_TYPE]) begin
            s_d.tmr_ext_ctl[`IC4_TC_EXT1_REQ] = ~EXT_N_I[1]; // RULE14
        end
        if (!s_q.ext23_ctl[`IC4_XC_EXT2_TYPE]) begin
            s_d.ext23_ctl[`IC4_XC_EXT2_REQ] = ~EXT_N_I[2]; // RULE13
        end
        if (!s_q.ext23_ctl[`IC4_XC_EXT3_TYPE]) begin
            s_d.ext23_ctl[`IC4_XC_EXT3_REQ] = ~EXT_N_I[3]; // RULE13
        end

        // Sample gated requests; they are polled in the following cycle.
        s_d.pend = src_flag & src_en
                   & {`IC4_NUM_SRC{s_q.pri_en[`IC4_GLOBAL_GATE_BIT]}}; // RULE2 RULE4

        // Read data, valid in the cycle after the strobe only.
        if (REG_REQ_I.rd) begin
            if (REG_REQ_I.addr == `IC4_ADR_TIMER_EXT_CTRL) begin
                s_d.rdata = s_q.tmr_ext_ctl;
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_EN) begin
                s_d.rdata = s_q.pri_en;
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_EN) begin
                s_d.rdata = s_q.xtr_en;
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_LO) begin
                s_d.rdata = s_q.xtr_lo;
            end else if (REG_REQ_I.addr == `IC4_ADR_EXTRA_PRIO_HI) begin
                s_d.rdata = s_q.xtr_hi;
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_HI) begin
                s_d.rdata = s_q.pri_hi;
            end else if (REG_REQ_I.addr == `IC4_ADR_PRIMARY_PRIO_LO) begin
                s_d.rdata = s_q.pri_lo;
            end else if (REG_REQ_I.addr == `IC4_ADR_EXT23_CTRL) begin
                s_d.rdata = s_q.ext23_ctl;
            end
        end
    end

    // State register; everything resets to zero, pins to their idle level.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            s_q <= '0; // RULE20
            s_q.pin <= `IC4_PIN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign RDATA_O = s_q.rdata;
    assign VEC_VALID_O = s_q.vec.valid;
    assign VEC_SRC_O = s_q.vec.src;
    assign VEC_ADDR_O = s_q.vec.addr;

    // Checks on the design's outputs and internal state.
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_no_pend_novec: assert property (s_q.pend == 14'h0000 |=> !VEC_VALID_O) // RULE2
        else $error("Vector issued with nothing pending.");
    a_gate_blocks: assert property (!s_q.pri_en[`IC4_GLOBAL_GATE_BIT] // RULE4
        |=> s_q.pend == 14'h0000)
        else $error("Request sampled while global gate is off.");
    a_vec_addr: assert property (VEC_VALID_O |->
        VEC_ADDR_O == 16'h0003 + {9'h000, VEC_SRC_O, 3'b000}) // RULE7
        else $error("Vector address does not match source.");
    a_block_return_from_interrupt: assert property (RETURN_FROM_INTERRUPT_I |=> !VEC_VALID_O) // RULE18
        else $error("Vector issued right after a return.");
    a_block_write: assert property (reg_hit && !INSTR_END_I |=> !VEC_VALID_O [*2]) // RULE18
        else $error("Vector issued during a blocked instruction.");
    a_only_at_end: assert property (VEC_VALID_O |-> $past(INSTR_END_I)) // RULE21
        else $error("Vector not at an instruction end.");
    a_strict_preempt: assert property (VEC_VALID_O |->
        ($past(s_q.act) == 4'h0) || (s_q.vec.lvl > $past(cur_lvl))) // RULE17
        else $error("Preempted an equal or higher level.");
    a_level_pushed: assert property (VEC_VALID_O |-> s_q.act[s_q.vec.lvl]) // RULE19
        else $error("Vectored level not recorded in service.");
    a_poll_order: assert property (VEC_VALID_O && $past(s_q.pend[0])
        && ($past(src_lvl[0]) == s_q.vec.lvl) |-> VEC_SRC_O == 4'h0) // RULE6
        else $error("Polling order not honoured.");
    a_edge_sets: assert property (s_q.tmr_ext_ctl[`IC4_TC_EXT0_TYPE] && fall[0] // RULE14
        |=> s_q.tmr_ext_ctl[`IC4_TC_EXT0_REQ])
        else $error("Falling edge on pin 0 lost.");
    a_level_follow: assert property (!s_q.ext23_ctl[`IC4_XC_EXT2_TYPE] // RULE13
        |=> s_q.ext23_ctl[`IC4_XC_EXT2_REQ] == !$past(EXT_N_I[2]))
        else $error("Level flag of pin 2 does not follow pin.");
endmodule // ic4_ctrl
`default_nettype wire

/* File: ic4_ctrl_tb.sv */
// Purpose: Self-checking bench for the four-level interrupt controller.
// Assumes: The core model paces instructions; the bench drives pins and flags.
// Notes: Every stimulus changes by non-blocking assignment at a rising edge.
`timescale 1ns/1ns
`default_nettype none
module ic4_ctrl_tb;
    import ic4_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ic4_req_s req = '0;
    logic [3:0] ext_n = 4'hF;
    logic t0 = 1'b0;
    logic t1 = 1'b0;
    logic [7:0] peri = 8'h00;
    logic [1:0] len = 2'h1;
    logic return_from_interrupt_req = 1'b0;
    logic instr_end, return_from_interrupt, vec_valid;
    logic [7:0] rdata;
    logic [3:0] vec_src;
    logic [15:0] vec_addr;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [7:0] ADR [8] = '{8'h88, 8'hA8, 8'hAD, 8'hAE, 8'hAF, 8'hB7, 8'hB8, 8'hC0};
    // Pin flags written while their pin is in level mode follow the idle pins, so they read 0.
    localparam logic [7:0] MSK [8] = '{8'hA5, 8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'h3F, 8'hDD};

    ic4_ctrl ic4_ctrl_i (.CLK_I(clk), .SYS_RST_I(rst), .REG_REQ_I(req), .RDATA_O(rdata),
        .EXT_N_I(ext_n), .T0_OVF_I(t0), .T1_OVF_I(t1), .PERI_REQ_I(peri),
        .INSTR_END_I(instr_end), .RETURN_FROM_INTERRUPT_I(return_from_interrupt), .VEC_VALID_O(vec_valid),
        .VEC_SRC_O(vec_src), .VEC_ADDR_O(vec_addr));
    ic4_core_model ic4_core_model_i (.CLK_I(clk), .SYS_RST_I(rst), .LEN_I(len),
        .RETURN_FROM_INTERRUPT_REQ_I(return_from_interrupt_req), .INSTR_END_O(instr_end), .RETURN_FROM_INTERRUPT_O(return_from_interrupt));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just then.
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        check($sformatf("register %h", a), {8'h00, exp}, {8'h00, rdata});
    endtask

    // Raises or drops the requests of every source set in the mask.
    task automatic fire(input logic [13:0] m, input logic on);
        @(posedge clk);
        for (int s = 0; s < 14; s++) begin
            if (m[s]) begin
                case (s)
                    0: ext_n[0] <= !on;
                    2: ext_n[1] <= !on;
                    6: ext_n[2] <= !on;
                    7: ext_n[3] <= !on;
                    1: t0 <= on;
                    3: t1 <= on;
                    4, 5: peri[s - 4] <= on;
                    default: peri[s - 6] <= on;
                endcase
            end
        end
        if (on && (m[1] || m[3])) begin
            @(posedge clk);
            t0 <= 1'b0;
            t1 <= 1'b0;
        end
    endtask

    task automatic wait_vec(input int s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (vec_valid !== 1'b1 && n < 40);
        check("vector taken", 16'h0001, {15'h0000, vec_valid});
        check("vector source", 16'(s), {12'h000, vec_src});
        check("vector address", 16'h0003 + 16'(8 * s), vec_addr);
    endtask

    task automatic no_vec(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            check("no vector", 16'h0000, {15'h0000, vec_valid});
        end
    endtask

    // Returns once the controller has seen the return instruction.
    task automatic ret();
        int n;
        n = 0;
        @(posedge clk);
        return_from_interrupt_req <= 1'b1;
        @(posedge clk);
        return_from_interrupt_req <= 1'b0;
        do begin
            @(posedge clk);
            n++;
        end while (return_from_interrupt !== 1'b1 && n < 8);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Cycle ceiling; the whole sequence needs well under two thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Main sequence of tests.
    initial begin
        logic [7:0] xc;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            reg_rd(ADR[i], 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            reg_wr(ADR[i], 8'hFF);
            reg_rd(ADR[i], MSK[i]);
            reg_wr(ADR[i], 8'h00);
        end
        reg_wr(8'hA9, 8'hFF);
        reg_rd(8'hA9, 8'h00);
        $display("test registers done");
        reg_wr(8'h88, 8'h05);
        for (int s = 0; s < 14; s++) begin
            @(posedge clk);
            len <= 2'(s % 3 + 1);
            xc = (s == 6) ? 8'h15 : ((s == 7) ? 8'h51 : 8'h11);
            reg_wr(8'hA8, (s < 6) ? (8'h80 | 8'(1 << s)) : 8'h80);
            reg_wr(8'hAD, (s > 7) ? 8'(1 << (s - 8)) : 8'h00);
            reg_wr(8'hC0, xc);
            fire(14'(1 << s), 1'b1);
            wait_vec(s);
            fire(14'(1 << s), 1'b0);
            reg_rd(8'h88, 8'h05);
            reg_rd(8'hC0, xc);
            ret();
        end
        $display("test vectors done");
        reg_wr(8'hC0, 8'h00);
        reg_wr(8'hAD, 8'h00);
        reg_wr(8'hA8, 8'h02);
        fire(14'h0002, 1'b1);
        no_vec(8);
        reg_rd(8'h88, 8'h25);
        reg_wr(8'hA8, 8'h82);
        wait_vec(1);
        ret();
        reg_wr(8'h88, 8'h25);
        wait_vec(1);
        ret();
        reg_wr(8'hA8, 8'h02);
        reg_wr(8'h88, 8'h25);
        reg_wr(8'h88, 8'h05);
        reg_wr(8'hA8, 8'h82);
        no_vec(8);
        $display("test gate and software flags done");
        reg_wr(8'hA8, 8'h8A);
        fire(14'h000A, 1'b1);
        wait_vec(1);
        ret();
        wait_vec(3);
        ret();
        $display("test polling order done");
        @(posedge clk);
        len <= 2'h3;
        reg_wr(8'hAF, 8'h20);
        reg_wr(8'hAE, 8'h20);
        reg_wr(8'hAD, 8'h20);
        reg_wr(8'hA8, 8'h81);
        fire(14'h2001, 1'b1);
        wait_vec(13);
        no_vec(12);
        fire(14'h2000, 1'b0);
        ret();
        no_vec(2);
        wait_vec(0);
        fire(14'h2000, 1'b1);
        wait_vec(13);
        fire(14'h2001, 1'b0);
        ret();
        ret();
        $display("test priority levels done");
        reg_wr(8'h88, 8'h00);
        reg_wr(8'hA8, 8'h84);
        fire(14'h0004, 1'b1);
        wait_vec(2);
        reg_rd(8'h88, 8'h08);
        fire(14'h0004, 1'b0);
        ret();
        no_vec(8);
        $display("test level trigger done");
        tally_and_finish();
    end
endmodule // ic4_ctrl_tb
`default_nettype wire

/* File: ic4_params.svh */
// Purpose: Constants for the four-level interrupt controller.
// Assumes: Included by the controller module only.
// Notes: Offsets are register-port addresses; masks clear unused bits.
`ifndef IC4_PARAMS_SVH
`define IC4_PARAMS_SVH

// Source count and level count.
`define IC4_NUM_SRC 14
`define IC4_NUM_LVL 4

// Register addresses.
`define IC4_ADR_TIMER_EXT_CTRL 8'h88
`define IC4_ADR_PRIMARY_EN 8'hA8
`define IC4_ADR_EXTRA_EN 8'hAD
`define IC4_ADR_EXTRA_PRIO_LO 8'hAE
`define IC4_ADR_EXTRA_PRIO_HI 8'hAF
`define IC4_ADR_PRIMARY_PRIO_HI 8'hB7
`define IC4_ADR_PRIMARY_PRIO_LO 8'hB8
`define IC4_ADR_EXT23_CTRL 8'hC0

// Reset value of every register and writable-bit masks.
`define IC4_REG_RST 8'h00
`define IC4_MASK_PRIMARY_EN 8'hBF
`define IC4_MASK_PRIMARY_LO 8'h3F
`define IC4_MASK_EXTRA 8'h3F
`define IC4_MASK_TIMER_EXT 8'hAF

// Field positions.
`define IC4_GLOBAL_GATE_BIT 7
`define IC4_SRC_FIELD 5:0
`define IC4_TC_T1_OVF 7
`define IC4_TC_T0_OVF 5
`define IC4_TC_EXT1_REQ 3
`define IC4_TC_EXT1_TYPE 2
`define IC4_TC_EXT0_REQ 1
`define IC4_TC_EXT0_TYPE 0
`define IC4_XC_EXT3_LO 7
`define IC4_XC_EXT3_EN 6
`define IC4_XC_EXT3_REQ 5
`define IC4_XC_EXT3_TYPE 4
`define IC4_XC_EXT2_LO 3
`define IC4_XC_EXT2_EN 2
`define IC4_XC_EXT2_REQ 1
`define IC4_XC_EXT2_TYPE 0

// Source numbers whose flags live here.
`define IC4_SRC_EXT0 4'h0
`define IC4_SRC_T0 4'h1
`define IC4_SRC_EXT1 4'h2
`define IC4_SRC_T1 4'h3
`define IC4_SRC_EXT2 4'h6
`define IC4_SRC_EXT3 4'h7

// Vector base and spacing as a shift.
`define IC4_VEC_BASE 16'h0003
`define IC4_VEC_SHIFT 3
// Idle level of the active-low pins.
`define IC4_PIN_IDLE 4'hF

`endif

/* File: ic4_pkg.sv */
// Purpose: Types shared by the four-level interrupt controller.
// Assumes: Constants come from ic4_params.svh.
// Notes: Widths are fixed at the documented values.
`default_nettype none
package ic4_pkg;
    typedef logic [1:0] ic4_lvl_t;

    // Register port request from software.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ic4_req_s;

    // Vector handed to the core.
    typedef struct packed {
        logic valid;
        logic [3:0] src;
        ic4_lvl_t lvl;
        logic [15:0] addr;
    } ic4_vec_s;

    // Whole state of the controller.
    typedef struct packed {
        logic [7:0] tmr_ext_ctl;
        logic [7:0] pri_en;
        logic [7:0] pri_lo;
        logic [7:0] pri_hi;
        logic [7:0] xtr_en;
        logic [7:0] xtr_lo;
        logic [7:0] xtr_hi;
        logic [7:0] ext23_ctl;
        logic [7:0] rdata;
        logic [3:0] pin;
        logic [13:0] pend;
        logic blk;
        logic [3:0] act;
        ic4_vec_s vec;
    } ic4_state_s;
endpackage
`default_nettype wire
